// ---- shared/scsi_pkg.sv ----
package scsi_pkg;
    // host register offsets
    localparam logic [3:0] REG_CMD    = 4'h3;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_DEST   = 4'h4;
    localparam logic [3:0] REG_INT    = 4'h5;

    // interrupt cause bit positions
    localparam int INT_BUSRST = 7;
    localparam int INT_BADCMD = 6;
    localparam int INT_DISC   = 5;
    localparam int INT_SVC    = 4;
    localparam int INT_DONE   = 3;
    localparam int INT_RESEL  = 2;
    localparam int INT_SELATN = 1;
    localparam int INT_SEL    = 0;

    // status bit positions
    localparam int ST_INT    = 7;
    localparam int ST_GROSS  = 6;
    localparam int ST_PARITY = 5;
    localparam int ST_TC     = 4;
    localparam int ST_VGC    = 3;

    localparam logic [7:0] INT_RESET = 8'h00;
    localparam int         CMD_DMA_BIT = 7;
    localparam int         PH_IO_BIT   = 0;

    // mode groups, command bits 6..4
    localparam logic [2:0] GRP_MISC = 3'h0;
    localparam logic [2:0] GRP_INIT = 3'h1;
    localparam logic [2:0] GRP_TARG = 3'h2;
    localparam logic [2:0] GRP_DISC = 3'h4;

    // highest used low code per group
    localparam logic [3:0] MISC_LAST = 4'h4;
    localparam logic [3:0] INIT_LAST = 4'h2;
    localparam logic [3:0] TARG_LAST = 4'h9;
    localparam logic [3:0] DISC_LAST = 4'h6;

    localparam logic [6:0] CMD_RESET_CHIP = 7'h02;
    localparam logic [6:0] CMD_RESET_BUS  = 7'h03;
    localparam logic [6:0] CMD_TSTOP_DMA  = 7'h04;
    localparam logic [6:0] CMD_RESELECT   = 7'h40;
    localparam logic [6:0] CMD_SEL_NOATN  = 7'h41;
    localparam logic [6:0] CMD_CHOSEN_WITH_ATTENTION_FLAG    = 7'h42;
    localparam logic [6:0] CMD_SEL_STOP   = 7'h43;
    localparam logic [6:0] CMD_SEL_ATN3   = 7'h46;

    // command block lengths
    localparam logic [3:0] CDB_LEN6  = 4'h6;
    localparam logic [3:0] CDB_LEN10 = 4'ha;
    localparam logic [3:0] CDB_LEN12 = 4'hc;

    localparam int CMDQ_DEPTH = 2;

    typedef enum logic [1:0] {
        MODE_DISC,
        MODE_TARG,
        MODE_INIT
    } scsi_mode_t;
endpackage

// ---- rtl/scsi_cmd_fifo.sv ----
`timescale 1ns/1ps
module scsi_cmd_fifo #(
    parameter int DEPTH = 2
) (
    input  wire logic       i_clock,     // chip clock
    input  wire logic       i_srst,      // sync reset, high
    input  wire logic       i_push,      // host write of a command
    input  wire logic [7:0] i_data,      // command byte
    input  wire logic       i_pop,       // bottom taken by sequencer
    output logic      [7:0] o_head,      // bottom entry
    output logic            o_valid,     // queue not empty
    output logic            o_overwrite  // top overwritten, pulse
);
    localparam int CW = $clog2(DEPTH + 1);

    generate
        if (DEPTH < 2) begin : g_bad_depth
            $error("scsi_cmd_fifo: DEPTH must be at least 2");
        end
    endgenerate

    typedef struct packed {
        logic [DEPTH-1:0][7:0] mem;
        logic [CW-1:0]         cnt;
        logic                  ovw;
    } scsi_fifo_t;

    scsi_fifo_t q;
    scsi_fifo_t d;

    always_comb begin
        d = q;
        d.ovw = 1'b0;
        if (i_pop && q.cnt != '0) begin
            for (int i = 0; i < DEPTH - 1; i++) begin
                d.mem[i] = q.mem[i+1];
            end
            d.cnt = q.cnt - CW'(1);
        end
        if (i_push) begin
            // full queue: newest command replaces the top entry
            if (d.cnt == CW'(DEPTH)) begin
                d.mem[DEPTH-1] = i_data;
                d.ovw = 1'b1;
            end else begin
                for (int i = 0; i < DEPTH; i++) begin
                    if (CW'(i) == d.cnt) begin
                        d.mem[i] = i_data;
                    end
                end
                d.cnt = d.cnt + CW'(1);
            end
        end
        if (i_srst) begin
            d.cnt = '0;
            d.ovw = 1'b0;
        end
    end

    always_ff @(posedge i_clock) begin
        q <= d;
    end

    assign o_head      = q.mem[0];
    assign o_valid     = (q.cnt != '0);
    assign o_overwrite = q.ovw;
endmodule

// ---- rtl/scsi_csi.sv ----
// Function
// RULE1 - second interrupt waits behind an unserviced first one
// RULE2 - reading interrupt register brings up the stacked interrupt's contents
// RULE3 - command bit 7 loads byte counter from stored count, else non-DMA
// RULE4 - bits 6-4 are mode group; misc group legal anywhere except target stop DMA
// RULE5 - unused code or wrong-mode group sets interrupt bit 6
// RULE6 - reset gives disconnected; selection events and select commands move mode
// RULE7 - status bits 7-5 and 3 stay latched until interrupt register read
// RULE8 - status bit 7 mirrors own interrupt drive; resets or read release it
// RULE9 - overwrites, direction clash, sync phase slip set gross error, no interrupt
// RULE10 - gross, parity, group flags clear on read with interrupt; not bus reset
// RULE11 - parity error sets bit 5; initiator info-in phase also raises ATN
// RULE12 - terminal count sets at zero, clears on counter load; read keeps it
// RULE13 - first command byte group decoded; group 2 valid only with SCSI-2
// RULE14 - groups 3, 4 reserved asking six bytes; group 6 six, 7 ten bytes
// RULE15 - phase bits live, or latched at completion and reopened by read
// RULE16 - target_id_select low three bits binary, driven one-hot; no reset
// RULE17 - read with interrupt clears interrupt, status, step; chip resets zero it
// RULE18 - bus reset sets interrupt bit 7 unless reporting disabled
// RULE19 - bit 5 on disconnect or time-out, or target terminate disconnect
// RULE20 - bit 4 on ATN in target mode or info request in initiator mode
// RULE21 - bit 3 on function completion in either mode
// RULE22 - selection sets bit 2, 1 or 0 by role and ATN
// RULE23 - command register queues up to two commands
// RULE24 - interrupt drives while any cause bit set, until read or reset
`timescale 1ns/1ps
module scsi_csi
    import scsi_pkg::*;
(
    input  wire logic       i_clock,        // 200 MHz chip clock
    input  wire logic       i_srst,         // hardware reset, sync high
    input  wire logic [3:0] i_addr,         // register address
    input  wire logic       i_cs,           // chip select
    input  wire logic       i_rd,           // read strobe
    input  wire logic       i_wr,           // write strobe
    input  wire logic [7:0] i_wdata,        // write data
    input  wire logic [2:0] i_phase,        // bus phase pins, async
    input  wire logic       i_parity_en,    // parity checking enabled
    input  wire logic       i_rst_rep_dis,  // bus reset reporting disabled
    input  wire logic       i_scsi2,        // SCSI-2 group decoding
    input  wire logic       i_phase_latch,  // phase latching enabled
    input  wire logic       i_cmd_done,     // sequencer finished command
    input  wire logic [2:0] i_seq_step,     // sequencer step count
    input  wire logic       i_tc_zero,      // transfer counter hit zero
    input  wire logic       i_fifo_ovw,     // data fifo top overwritten
    input  wire logic       i_dir_err,      // DMA against bus direction
    input  wire logic       i_sync_slip,    // sync data phase change
    input  wire logic       i_parity_err,   // incoming byte parity bad
    input  wire logic       i_bus_reset,    // bus reset seen
    input  wire logic       i_selected,     // selected as target
    input  wire logic       i_chosen_with_attention_flag,      // ATN during selection
    input  wire logic       i_reselected,   // reselected as initiator
    input  wire logic       i_disconnect,   // bus disconnect
    input  wire logic       i_sel_timeout,  // select time-out
    input  wire logic       i_atn_seen,     // initiator raised ATN
    input  wire logic       i_info_req,     // target asks info phase
    input  wire logic       i_func_done,    // function complete event
    input  wire logic       i_cdb_first,    // first command byte strobe
    input  wire logic [7:0] i_cdb_byte,     // first command byte
    output logic      [7:0] o_rdata,        // register read data
    output logic            o_int,          // interrupt drive
    output logic            o_cmd_start,    // command to sequencer, pulse
    output logic      [7:0] o_cmd_code,     // dispatched command
    output logic            o_load_count,   // load byte counter, pulse
    output logic            o_bus_rst_cmd,  // reset bus command, pulse
    output logic            o_atn_assert,   // raise ATN, pulse
    output logic      [3:0] o_cdb_len,      // command bytes to request
    output logic      [7:0] o_dest_sel,     // one-hot target_id_select
    output scsi_mode_t      o_mode          // current role
);
    typedef struct packed {
        logic [2:0] ph_m;
        logic [2:0] ph_s;
        scsi_mode_t mode;
        logic       busy;
        logic       soft_rst;
        logic [7:0] last_cmd;
        logic [7:0] cur_int;
        logic [7:0] pend_int;
        logic [2:0] cur_st;   // gross, parity, valid group
        logic [2:0] pend_st;
        logic [2:0] cur_seq;
        logic [2:0] pend_seq;
        logic [2:0] cur_ph;
        logic [2:0] pend_ph;
        logic       ph_closed;
        logic       pend_ph_ok;
        logic       tc;
        logic [2:0] dest_id;
        logic       int_out;
        logic [7:0] rdata;
        logic       start;
        logic [7:0] code;
        logic       load;
        logic       bus_rst;
        logic       atn;
        logic [3:0] cdb_len;
        logic [7:0] dest_sel;
    } scsi_csi_t;

    scsi_csi_t q;
    scsi_csi_t d;

    logic [7:0] fifo_head;
    logic       fifo_valid;
    logic       fifo_ovw;
    logic       fifo_pop;
    logic       fifo_push;
    logic       wr_cmd;
    logic       rd_int;

    function automatic logic code_used(input logic [6:0] c);
        case (c[6:4])
            GRP_MISC: code_used = (c[3:0] <= MISC_LAST);
            GRP_INIT: code_used = (c[3:0] <= INIT_LAST);
            GRP_TARG: code_used = (c[3:0] <= TARG_LAST);
            GRP_DISC: code_used = (c[3:0] <= DISC_LAST);
            default:  code_used = 1'b0;
        endcase
    endfunction

    function automatic logic group_ok(input logic [6:0] c, input scsi_mode_t m);
        case (c[6:4])
            GRP_MISC: group_ok = (c != CMD_TSTOP_DMA) || (m == MODE_TARG);
            GRP_INIT: group_ok = (m == MODE_INIT);
            GRP_TARG: group_ok = (m == MODE_TARG);
            GRP_DISC: group_ok = (m == MODE_DISC);
            default:  group_ok = 1'b0;
        endcase
    endfunction

    // {valid, length}
    function automatic logic [4:0] cdb_decode(input logic [2:0] g, input logic s2);
        case (g)
            3'h0:    cdb_decode = {1'b1, CDB_LEN6};
            3'h1:    cdb_decode = {1'b1, CDB_LEN10};
            3'h2:    cdb_decode = s2 ? {1'b1, CDB_LEN10} : {1'b0, CDB_LEN6};
            3'h5:    cdb_decode = {1'b1, CDB_LEN12};
            3'h6:    cdb_decode = {1'b1, CDB_LEN6};
            3'h7:    cdb_decode = {1'b1, CDB_LEN10};
            default: cdb_decode = {1'b0, CDB_LEN6};
        endcase
    endfunction

    assign wr_cmd    = i_cs && i_wr && (i_addr == REG_CMD);
    assign rd_int    = i_cs && i_rd && (i_addr == REG_INT);
    // chip and bus reset run at once and never enter the queue
    assign fifo_push = wr_cmd && (i_wdata[6:0] != CMD_RESET_CHIP) && (i_wdata[6:0] != CMD_RESET_BUS);
    assign fifo_pop  = fifo_valid && !q.busy && !q.start && !q.soft_rst;

    scsi_cmd_fifo #(
        .DEPTH (CMDQ_DEPTH) // RULE23
    ) u_cmdq (
        .i_clock     (i_clock),
        .i_srst      (i_srst || q.soft_rst),
        .i_push      (fifo_push),
        .i_data      (i_wdata),
        .i_pop       (fifo_pop),
        .o_head      (fifo_head),
        .o_valid     (fifo_valid),
        .o_overwrite (fifo_ovw)
    );

    always_comb begin
        logic       clr;
        logic       stack;
        logic [7:0] ev;
        logic [2:0] st_ev;
        logic [4:0] dec;
        logic [2:0] live_ph;
        clr     = 1'b0;
        stack   = 1'b0;
        ev      = 8'h00;
        st_ev   = 3'h0;
        dec     = 5'h00;
        live_ph = q.ph_s;

        d = q;
        d.ph_m     = i_phase;
        d.ph_s     = q.ph_m;
        d.soft_rst = 1'b0;
        d.start    = 1'b0;
        d.load     = 1'b0;
        d.bus_rst  = 1'b0;
        d.atn      = 1'b0;

        if (i_cmd_done) begin
            d.busy = 1'b0;
        end

        // dispatch of the bottom command
        if (fifo_pop) begin
            d.last_cmd = fifo_head;
            if (!code_used(fifo_head[6:0]) || !group_ok(fifo_head[6:0], q.mode)) begin // RULE4
                ev[INT_BADCMD] = 1'b1; // RULE5
            end else begin
                d.start = 1'b1;
                d.code  = fifo_head;
                d.busy  = 1'b1;
                if (fifo_head[CMD_DMA_BIT]) begin
                    d.load = 1'b1; // RULE3
                    d.tc   = 1'b0; // RULE12
                end
                if (fifo_head[6:0] == CMD_SEL_NOATN || fifo_head[6:0] == CMD_CHOSEN_WITH_ATTENTION_FLAG ||
                    fifo_head[6:0] == CMD_SEL_STOP || fifo_head[6:0] == CMD_SEL_ATN3) begin
                    d.mode = MODE_INIT; // RULE6
                end else if (fifo_head[6:0] == CMD_RESELECT) begin
                    d.mode = MODE_TARG; // RULE6
                end
            end
        end

        if (wr_cmd && i_wdata[6:0] == CMD_RESET_CHIP) begin
            d.soft_rst = 1'b1;
        end
        if (wr_cmd && i_wdata[6:0] == CMD_RESET_BUS) begin
            d.bus_rst  = 1'b1;
            d.last_cmd = i_wdata;
        end
        if (i_cs && i_wr && i_addr == REG_DEST) begin
            d.dest_id = i_wdata[2:0]; // RULE16
        end
        d.dest_sel = 8'h01 << d.dest_id; // RULE16

        // bus side events
        if (i_bus_reset && !i_rst_rep_dis) begin
            ev[INT_BUSRST] = 1'b1; // RULE18
        end
        if (i_disconnect || i_sel_timeout) begin
            ev[INT_DISC] = 1'b1; // RULE19
        end
        if ((i_atn_seen && q.mode == MODE_TARG) || (i_info_req && q.mode == MODE_INIT)) begin
            ev[INT_SVC] = 1'b1; // RULE20
        end
        if (i_func_done) begin
            ev[INT_DONE] = 1'b1; // RULE21
        end
        if (i_reselected) begin
            ev[INT_RESEL] = 1'b1; // RULE22
            d.mode        = MODE_INIT; // RULE6
        end
        if (i_selected) begin
            ev[INT_SELATN] = i_chosen_with_attention_flag; // RULE22
            ev[INT_SEL]    = !i_chosen_with_attention_flag; // RULE22
            d.mode         = MODE_TARG; // RULE6
        end
        if (i_bus_reset || i_disconnect || i_sel_timeout) begin
            d.mode = MODE_DISC;
        end
        if (i_bus_reset || i_disconnect || i_sel_timeout || i_selected || i_reselected) begin
            d.busy = 1'b0;
        end

        st_ev[2] = fifo_ovw || i_fifo_ovw || i_dir_err || i_sync_slip; // RULE9
        st_ev[1] = i_parity_en && i_parity_err; // RULE11
        if (st_ev[1] && q.mode == MODE_INIT && live_ph[PH_IO_BIT]) begin
            d.atn = 1'b1; // RULE11
        end
        if (i_cdb_first) begin
            dec       = cdb_decode(i_cdb_byte[7:5], i_scsi2); // RULE13 RULE14
            d.cdb_len = dec[3:0];
            st_ev[0]  = dec[4]; // RULE13
        end

        // a read with interrupt up pops the stacked set; new events still land
        clr = rd_int && q.int_out; // RULE17
        if (clr) begin
            d.cur_int  = q.pend_int; // RULE2
            d.cur_st   = q.pend_st; // RULE10
            d.cur_seq  = q.pend_seq;
            d.pend_int = 8'h00;
            d.pend_st  = 3'h0;
            d.pend_seq = 3'h0;
            if (q.pend_ph_ok) begin
                d.cur_ph     = q.pend_ph; // RULE15
                d.pend_ph_ok = 1'b0;
            end else begin
                d.ph_closed = 1'b0; // RULE15
            end
        end
        stack = (d.cur_int != 8'h00) && (q.int_out || clr); // RULE1
        if (stack) begin
            d.pend_int = d.pend_int | ev; // RULE1
            d.pend_st  = d.pend_st | st_ev;
            if (ev != 8'h00) begin
                d.pend_seq = i_seq_step;
            end
        end else begin
            d.cur_int = d.cur_int | ev; // RULE7
            d.cur_st  = d.cur_st | st_ev; // RULE7
            if (ev != 8'h00) begin
                d.cur_seq = i_seq_step;
            end
        end

        // phase latch: open latch follows the bus
        if (!d.ph_closed) begin
            d.cur_ph = live_ph;
        end
        if (i_phase_latch && i_cmd_done) begin
            if (!d.ph_closed) begin
                d.ph_closed = 1'b1; // RULE15
            end else begin
                d.pend_ph    = live_ph;
                d.pend_ph_ok = 1'b1;
            end
        end
        if (!i_phase_latch) begin
            d.ph_closed  = 1'b0;
            d.pend_ph_ok = 1'b0;
        end

        if (i_tc_zero) begin
            d.tc = 1'b1; // RULE12
        end

        // registered read data shows state before this cycle's clear
        d.rdata = 8'h00;
        if (i_cs && i_rd) begin
            case (i_addr)
                REG_CMD:    d.rdata = q.last_cmd;
                REG_STATUS: d.rdata = {q.int_out, q.cur_st[2:1], q.tc, q.cur_st[0], // RULE8
                                       (i_phase_latch ? q.cur_ph : live_ph)}; // RULE15
                REG_INT:    d.rdata = q.cur_int;
                default:    d.rdata = 8'h00;
            endcase
        end

        d.int_out = (d.cur_int != 8'h00); // RULE24 RULE8

        if (i_srst || q.soft_rst) begin
            d.mode       = MODE_DISC; // RULE6
            d.busy       = 1'b0;
            d.cur_int    = INT_RESET; // RULE17
            d.pend_int   = INT_RESET;
            d.cur_st     = 3'h0; // RULE10
            d.pend_st    = 3'h0;
            d.cur_seq    = 3'h0;
            d.pend_seq   = 3'h0;
            d.ph_closed  = 1'b0;
            d.pend_ph_ok = 1'b0;
            d.tc         = 1'b0; // RULE12
            d.int_out    = 1'b0; // RULE8
            d.start      = 1'b0;
            d.load       = 1'b0;
            d.bus_rst    = 1'b0;
            d.atn        = 1'b0;
            d.soft_rst   = 1'b0;
            d.cdb_len    = CDB_LEN6;
            d.code       = 8'h00;
            d.last_cmd   = 8'h00;
            if (i_srst) begin
                d.rdata = 8'h00;
            end
        end
    end

    always_ff @(posedge i_clock) begin
        q <= d;
    end

    assign o_rdata       = q.rdata;
    assign o_int         = q.int_out;
    assign o_cmd_start   = q.start;
    assign o_cmd_code    = q.code;
    assign o_load_count  = q.load;
    assign o_bus_rst_cmd = q.bus_rst;
    assign o_atn_assert  = q.atn;
    assign o_cdb_len     = q.cdb_len;
    assign o_dest_sel    = q.dest_sel;
    assign o_mode        = q.mode;

    property p_stack_hold;
        @(posedge i_clock) disable iff (i_srst)
        (o_int && !rd_int && !q.soft_rst) |=> (q.cur_int == $past(q.cur_int));
    endproperty
    a_stack_hold: assert property (p_stack_hold) else $error("interrupt changed before read"); // RULE1

    property p_pop_pending;
        @(posedge i_clock) disable iff (i_srst)
        (rd_int && o_int && q.pend_int != 8'h00 && !q.soft_rst) |=> (o_int && q.cur_int != 8'h00);
    endproperty
    a_pop_pending: assert property (p_pop_pending) else $error("stacked interrupt lost on read"); // RULE2

    property p_dma_load;
        @(posedge i_clock) disable iff (i_srst)
        o_cmd_start |-> (o_load_count == o_cmd_code[CMD_DMA_BIT]);
    endproperty
    a_dma_load: assert property (p_dma_load) else $error("counter load disagrees with dma bit"); // RULE3

    property p_bad_cmd;
        @(posedge i_clock) disable iff (i_srst)
        (fifo_pop && !group_ok(fifo_head[6:0], q.mode) && !q.int_out)
            |=> (!o_cmd_start && q.cur_int[INT_BADCMD]);
    endproperty
    a_bad_cmd: assert property (p_bad_cmd) else $error("wrong-mode command not flagged"); // RULE5

    property p_int_mirror;
        @(posedge i_clock) disable iff (i_srst)
        (i_cs && i_rd && i_addr == REG_STATUS) |=> (o_rdata[ST_INT] == $past(o_int));
    endproperty
    a_int_mirror: assert property (p_int_mirror) else $error("status bit 7 differs from drive"); // RULE8

    // only cycles free of any cause event, so an unchanged cause set proves no interrupt
    property p_gross;
        @(posedge i_clock) disable iff (i_srst)
        ((fifo_ovw || i_fifo_ovw) && !q.soft_rst && !q.int_out && !fifo_pop && !i_func_done &&
         !i_selected && !i_reselected && !i_bus_reset && !i_disconnect && !i_sel_timeout &&
         !i_atn_seen && !i_info_req)
            |=> (q.cur_st[2] && q.cur_int == $past(q.cur_int));
    endproperty
    a_gross: assert property (p_gross) else $error("gross error not set or raised interrupt"); // RULE9

    property p_tc_keep;
        @(posedge i_clock) disable iff (i_srst)
        (q.tc && rd_int && !q.soft_rst && !o_load_count) |=> q.tc;
    endproperty
    a_tc_keep: assert property (p_tc_keep) else $error("terminal count cleared by read"); // RULE12

    property p_int_follows;
        @(posedge i_clock) disable iff (i_srst)
        (q.cur_int != 8'h00) |-> o_int;
    endproperty
    a_int_follows: assert property (p_int_follows) else $error("cause set without interrupt"); // RULE24

    property p_busrst;
        @(posedge i_clock) disable iff (i_srst)
        (i_bus_reset && i_rst_rep_dis && q.cur_int == 8'h00 && !q.soft_rst) |=> !q.cur_int[INT_BUSRST];
    endproperty
    a_busrst: assert property (p_busrst) else $error("masked bus reset reported"); // RULE18

    c_stacked: cover property (@(posedge i_clock) disable iff (i_srst) o_int && q.pend_int != 8'h00);
    c_dma_cmd: cover property (@(posedge i_clock) disable iff (i_srst) o_load_count);
    c_bad_cmd: cover property (@(posedge i_clock) disable iff (i_srst) q.cur_int[INT_BADCMD]);
    c_sel:     cover property (@(posedge i_clock) disable iff (i_srst) o_mode == MODE_TARG);
endmodule

// ---- dv/scsi_bus_model.sv ----
`timescale 1ns/1ps
module scsi_bus_model (
    input  wire logic       i_clock, // chip clock
    input  wire logic [7:0] i_kick,  // event request from bench
    input  wire logic [2:0] i_ph,    // phase to present
    output logic      [7:0] o_ev,    // bus event pulses
    output logic      [2:0] o_phase  // bus phase lines
);
    // launched just after a rising edge, one cycle wide
    always_ff @(posedge i_clock) begin
        o_ev    <= i_kick;
        o_phase <= i_ph;
    end
endmodule

// ---- dv/test_scsi_csi.sv ----
`timescale 1ns/1ps
module test_scsi_csi;
    import scsi_pkg::*;
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin error_cnt++; $display("Error %s %h %h", n, e, a); end end
    logic        clk = 1'b0, srst = 1'b1, cs = 1'b0, rd = 1'b0, wr = 1'b0, rdis = 1'b0, plat = 1'b0;
    logic [3:0]  addr = 4'h0, clen;
    logic [7:0]  wd = 8'h00, rdat, dsel, ccode, bev;
    logic [2:0]  ph = 3'h0, bph;
    logic [15:0] ev = 16'h0000;
    logic        oint, start, load, brst, atn;
    scsi_mode_t  mode;
    int          error_cnt = 0, checks = 0;
    scsi_bus_model bus (.i_clock(clk), .i_kick(ev[7:0]), .i_ph(ph), .o_ev(bev), .o_phase(bph));
    scsi_csi uut (
        .i_clock(clk), .i_srst(srst), .i_addr(addr), .i_cs(cs), .i_rd(rd), .i_wr(wr), .i_wdata(wd),
        .i_phase(bph), .i_parity_en(1'b1), .i_rst_rep_dis(rdis), .i_scsi2(1'b0), .i_phase_latch(plat),
        .i_cmd_done(ev[8]), .i_seq_step(3'h0), .i_tc_zero(ev[9]), .i_fifo_ovw(ev[10]), .i_dir_err(ev[11]),
        .i_sync_slip(ev[12]), .i_parity_err(ev[13]), .i_bus_reset(bev[0]), .i_selected(bev[1]),
        .i_chosen_with_attention_flag(bev[2]), .i_reselected(bev[3]), .i_disconnect(bev[4]), .i_sel_timeout(bev[5]),
        .i_atn_seen(bev[6]), .i_info_req(bev[7]), .i_func_done(ev[14]), .i_cdb_first(ev[15]),
        .i_cdb_byte(8'h28), .o_rdata(rdat), .o_int(oint), .o_cmd_start(start), .o_cmd_code(ccode),
        .o_load_count(load), .o_bus_rst_cmd(brst), .o_atn_assert(atn), .o_cdb_len(clen),
        .o_dest_sel(dsel), .o_mode(mode));
    task automatic conclude();
        if (error_cnt == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d, output logic [7:0] r);
        @(negedge clk);
        {cs, rd, wr, addr, wd} = {1'b1, !w, w, a, d};
        @(negedge clk);
        {cs, rd, wr} = 3'h0;
        r = rdat;
    endtask
    // bus events arrive one cycle late through the model
    task automatic pulse(input logic [15:0] e);
        @(negedge clk);
        ev = e;
        @(negedge clk);
        ev = 16'h0000;
        repeat (3) @(negedge clk);
    endtask
    task automatic wint();
        int n;
        n = 0;
        while (oint !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        if (oint !== 1'b1) begin
            error_cnt++;
            conclude();
        end
    endtask
    task automatic t_reset();
        logic [7:0] r;
        `CHK("mode", MODE_DISC, mode)
        `CHK("cdb_len", CDB_LEN6, clen)
        acc(1'b0, REG_INT, 8'h00, r);
        `CHK("int", INT_RESET, r)
    endtask
    task automatic t_gross();
        logic [7:0] r;
        pulse(16'ha400);
        `CHK("int quiet", 1'b0, oint)
        `CHK("cdb len", CDB_LEN10, clen)
        acc(1'b1, REG_CMD, 8'h11, r);
        wint();
        acc(1'b0, REG_STATUS, 8'h00, r);
        `CHK("st flags", 5'h1d, r[7:3])
        acc(1'b0, REG_INT, 8'h00, r);
        `CHK("bad cmd", 8'h40, r)
        `CHK("int low", 1'b0, oint)
        acc(1'b0, REG_STATUS, 8'h00, r);
        `CHK("st clear", 5'h00, r[7:3])
    endtask
    task automatic t_tc();
        logic [7:0] r;
        acc(1'b1, REG_CMD, 8'h80, r);
        @(negedge clk);
        `CHK("load", 1'b1, load)
        `CHK("code", 8'h80, ccode)
        pulse(16'h0300);
        acc(1'b1, REG_CMD, 8'h00, r);
        @(negedge clk);
        `CHK("nop start", 2'h2, {start, load})
        pulse(16'h0100);
        acc(1'b0, REG_INT, 8'h00, r);
        acc(1'b0, REG_STATUS, 8'h00, r);
        `CHK("tc kept", 1'b1, r[ST_TC])
        acc(1'b1, REG_CMD, 8'h80, r);
        pulse(16'h0100);
        acc(1'b0, REG_STATUS, 8'h00, r);
        `CHK("tc cleared", 1'b0, r[ST_TC])
        acc(1'b1, REG_CMD, 8'h00, r);
        acc(1'b1, REG_CMD, 8'h80, r);
        `CHK("queued", 8'h00, ccode)
        pulse(16'h0100);
        `CHK("dequeued", 8'h80, ccode)
    endtask
    task automatic t_misc();
        logic [7:0] r;
        acc(1'b1, REG_DEST, 8'h07, r);
        @(negedge clk);
        `CHK("dest", 8'h80, dsel)
        ph = 3'h3;
        repeat (5) @(negedge clk);
        acc(1'b0, REG_STATUS, 8'h00, r);
        `CHK("phase", 3'h3, r[2:0])
        pulse(16'h0008);
        acc(1'b0, REG_INT, 8'h00, r);
        `CHK("resel", 8'h04, r)
        `CHK("init", MODE_INIT, mode)
        ev = 16'h2000;
        @(negedge clk);
        ev = 16'h0000;
        `CHK("atn", 1'b1, atn)
        plat = 1'b1;
        pulse(16'h4100);
        ph = 3'h5;
        repeat (5) @(negedge clk);
        acc(1'b0, REG_STATUS, 8'h00, r);
        `CHK("ph latched", 3'h3, r[2:0])
        acc(1'b0, REG_INT, 8'h00, r);
        `CHK("done", 8'h08, r)
        acc(1'b0, REG_STATUS, 8'h00, r);
        `CHK("ph open", 3'h5, r[2:0])
        plat = 1'b0;
        rdis = 1'b1;
        pulse(16'h0001);
        `CHK("no report", 1'b0, oint)
        rdis = 1'b0;
        pulse(16'h0001);
        acc(1'b0, REG_INT, 8'h00, r);
        `CHK("bus rst", 8'h80, r)
    endtask
    // second cause lands while the first is unserviced
    task automatic t_stack();
        logic [7:0] r;
        pulse(16'h0006);
        `CHK("mode", MODE_TARG, mode)
        pulse(16'h0040);
        acc(1'b0, REG_INT, 8'h00, r);
        `CHK("first", 8'h02, r)
        @(negedge clk);
        `CHK("still", 1'b1, oint)
        acc(1'b0, REG_INT, 8'h00, r);
        `CHK("second", 8'h10, r)
        pulse(16'h0001);
        acc(1'b1, REG_CMD, 8'h02, r);
        @(negedge clk);
        `CHK("soft int", 1'b0, oint)
        acc(1'b1, REG_CMD, 8'h03, r);
        `CHK("bus rst cmd", 1'b1, brst)
    endtask
    initial begin
        forever #2.5 clk = ~clk;
    end
    initial begin
        repeat (8) @(negedge clk);
        srst = 1'b0;
        t_reset();
        t_gross();
        t_tc();
        t_misc();
        t_stack();
        conclude();
    end
endmodule
